// ==== sirq_consts.vh ====
`ifndef SIRQ_CONSTS_VH
`define SIRQ_CONSTS_VH
// register addresses of the first port instance
`define SIRQ_A_ABSTAT 16'hf0b8
`define SIRQ_A_FSTAT 16'hf0ba
`define SIRQ_A_TXFCON 16'hf0c4
`define SIRQ_A_RXFCON 16'hf0c6
`define SIRQ_A_ABIC 16'hf15c
`define SIRQ_A_TBIC 16'hf19c
`define SIRQ_A_ABCON 16'hf1b8
`define SIRQ_A_PMW 16'hfeaa
`define SIRQ_A_THOLD 16'hfeb0
`define SIRQ_A_RHOLD 16'hfeb2
`define SIRQ_A_BG 16'hfeb4
`define SIRQ_A_FDV 16'hfeb6
`define SIRQ_A_TIC 16'hff6c
`define SIRQ_A_RIC 16'hff6e
`define SIRQ_A_EIC 16'hff70
`define SIRQ_A_PCON 16'hffb0
`define SIRQ_A_ISTAT 16'hf0c8
`define SIRQ_A_IMASK 16'hf0ca
// port_control fields
`define SIRQ_M_MSB 2
`define SIRQ_M_LSB 0
`define SIRQ_REN 4
`define SIRQ_PEN 5
`define SIRQ_FEN 6
`define SIRQ_OEN 7
`define SIRQ_PE 8
`define SIRQ_FE 9
`define SIRQ_OE 10
`define SIRQ_ODD 12
// mode codes
`define SIRQ_MODE_SYNC 3'h0
`define SIRQ_MODE_P7 3'h3
`define SIRQ_MODE_P8 3'h7
// queue control fields
`define SIRQ_QEN 0
`define SIRQ_QFLU 1
`define SIRQ_QTM 2
`define SIRQ_QLVL_MSB 11
`define SIRQ_QLVL_LSB 8
// fill status fields
`define SIRQ_FS_RX_MSB 3
`define SIRQ_FS_RX_LSB 0
`define SIRQ_FS_TX_MSB 11
`define SIRQ_FS_TX_LSB 8
// reset values
`define SIRQ_PCON_RST 16'h0000
`define SIRQ_QCON_RST 16'h0100
`define SIRQ_MASK_RST 3'h0
// queue geometry and request width
`define SIRQ_QDEPTH 4'h8
`define SIRQ_REQ_CYC 2'h2
`endif

// ==== sirq_event_logic.v ====
// Functional notes
// - async, no queue: receive request on each frame moved to holding.
// - queue on, transparent off: receive request when fill reaches threshold.
// - sync, holding still unread at new frame: receive and error requests.
// - frame into full receive queue: both requests, newest entry overwritten.
// - reading an empty receive queue raises an error request.
// - transparent read leaving entries raises a receive request again.
// - writing the transmit flush bit raises a transmit holding request.
// - enabling transmit queue with transparent mode from off: holding request.
// - write to full transmit queue: error request, newest entry overwritten.
// - async stop bit low: receive and error requests, framing flag.
// - parity mismatch: receive and error requests, parity flag.
// - every request line stays active two clock cycles after its latest event.
// - error flags stay set until software clears them.
// - overrun check on and unread frame replaced: overrun flag, error request.
`timescale 1ns/100ps
`include "sirq_consts.vh"
module sirq_event_logic (
  input wire core_clk_in,
  input wire rst_in,
  input wire [15:0] reg_addr_in,
  input wire [15:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [15:0] reg_rdata_out,
  input wire rx_frame_in,
  input wire [8:0] rx_data_in,
  input wire rx_stop_in,
  input wire tx_take_in,
  output reg [8:0] tx_data_out,
  output wire tx_ready_out,
  output wire receive_request_line_out,
  output wire error_request_line_out,
  output wire transmit_holding_request_line_out,
  output wire irq_out
);
  // software visible state
  reg [15:0] port_control;
  reg [15:0] tx_queue_control;
  reg [15:0] rx_queue_control;
  reg [15:0] transmit_holding;
  reg [2:0] irq_status;
  reg [2:0] irq_mask;

  // decoded fields
  wire [2:0] mode;
  wire sync_mode;
  wire rx_qen;
  wire rx_tm;
  wire [3:0] rx_lvl;
  wire tx_qen;
  wire tx_tm;
  wire [3:0] tx_lvl;
  wire overrun_check_enable;

  // bus decode strobes
  wire wr_pcon;
  wire wr_txfc;
  wire wr_rxfc;
  wire wr_thold;
  wire wr_mask;
  wire rd_rhold;
  wire rd_stat;

  // queue status
  wire [8:0] rx_head;
  wire [3:0] rx_cnt;
  wire rx_full;
  wire rx_empty;
  wire [8:0] tx_head;
  wire [3:0] tx_cnt;
  wire tx_full;
  wire tx_empty;
  wire rx_flush;
  wire tx_flush;

  // receive side checks
  wire parity_mode;
  wire calc_par;
  wire got_par;
  wire framing_err;
  wire parity_err;
  wire rx_ovf;
  wire buf_unread;
  wire sync_err;
  wire overrun_ev;
  wire rd_empty;
  wire tm_read;
  wire rx_thr;
  wire rx_each;
  wire rx_pop;

  // transmit side events
  wire tx_ovf;
  wire tx_take_ev;
  wire tb_take;
  wire tx_enable_ev;

  // per line collection
  wire rx_ev;
  wire er_ev;
  wire tb_ev;
  wire [2:0] ev;
  wire [2:0] lines;

  // field extraction
  assign mode = port_control[`SIRQ_M_MSB:`SIRQ_M_LSB];
  assign sync_mode = (mode == `SIRQ_MODE_SYNC);
  assign overrun_check_enable = port_control[`SIRQ_OEN];
  assign rx_qen = rx_queue_control[`SIRQ_QEN];
  assign rx_tm = rx_queue_control[`SIRQ_QTM];
  assign rx_lvl = rx_queue_control[`SIRQ_QLVL_MSB:`SIRQ_QLVL_LSB];
  assign tx_qen = tx_queue_control[`SIRQ_QEN];
  assign tx_tm = tx_queue_control[`SIRQ_QTM];
  assign tx_lvl = tx_queue_control[`SIRQ_QLVL_MSB:`SIRQ_QLVL_LSB];

  // address decode
  assign wr_pcon = reg_wr_in & (reg_addr_in == `SIRQ_A_PCON);
  assign wr_txfc = reg_wr_in & (reg_addr_in == `SIRQ_A_TXFCON);
  assign wr_rxfc = reg_wr_in & (reg_addr_in == `SIRQ_A_RXFCON);
  assign wr_thold = reg_wr_in & (reg_addr_in == `SIRQ_A_THOLD);
  assign wr_mask = reg_wr_in & (reg_addr_in == `SIRQ_A_IMASK);
  assign rd_rhold = reg_rd_in & (reg_addr_in == `SIRQ_A_RHOLD);
  assign rd_stat = reg_rd_in & (reg_addr_in == `SIRQ_A_ISTAT);

  // a flush bit or a change of the enable empties the queue
  assign rx_flush = wr_rxfc &
    (reg_wdata_in[`SIRQ_QFLU] | (reg_wdata_in[`SIRQ_QEN] != rx_qen));
  assign tx_flush = wr_txfc &
    (reg_wdata_in[`SIRQ_QFLU] | (reg_wdata_in[`SIRQ_QEN] != tx_qen));

  // receive queue, a single holding word when the queue is off
  // guarded queue
  sirq_queue u_rxq (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .flush_in(rx_flush),
    .push_in(rx_frame_in),
    .pop_in(rd_rhold),
    .data_in(rx_data_in),
    .cap_in(rx_qen ? `SIRQ_QDEPTH : 4'h1),
    .head_out(rx_head),
    .count_out(rx_cnt),
    .full_out(rx_full),
    .empty_out(rx_empty)
  );

  // transmit queue, drained by the shifter
  // guarded queue
  sirq_queue u_txq (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .flush_in(tx_flush),
    .push_in(wr_thold),
    .pop_in(tx_take_in),
    .data_in(reg_wdata_in[8:0]),
    .cap_in(tx_qen ? `SIRQ_QDEPTH : 4'h1),
    .head_out(tx_head),
    .count_out(tx_cnt),
    .full_out(tx_full),
    .empty_out(tx_empty)
  );

  // the shifter may take a word while anything is queued
  assign tx_ready_out = ~tx_empty;

  // a read in the cycle of an arrival frees a slot, so that frame is not lost
  assign rx_pop = rd_rhold & ~rx_empty;

  // parity over 7 or 8 data bits, odd select inverts the expectation
  // even parity: data ones plus the parity bit make an even count
  assign parity_mode = (mode == `SIRQ_MODE_P7) | (mode == `SIRQ_MODE_P8);
  assign calc_par = ((mode == `SIRQ_MODE_P7) ? (^rx_data_in[6:0]) : (^rx_data_in[7:0])) ^
    port_control[`SIRQ_ODD];
  assign got_par = (mode == `SIRQ_MODE_P7) ? rx_data_in[7] : rx_data_in[8];

  assign framing_err = rx_frame_in & ~sync_mode & port_control[`SIRQ_FEN] & ~rx_stop_in;
  assign parity_err = rx_frame_in & port_control[`SIRQ_PEN] & parity_mode &
    (got_par != calc_par);

  assign rx_ovf = rx_frame_in & rx_qen & rx_full & ~rx_pop;
  assign buf_unread = rx_frame_in & ~rx_qen & rx_full & ~rx_pop;
  assign sync_err = buf_unread & sync_mode;
  assign overrun_ev = rx_frame_in & overrun_check_enable & rx_full & ~rx_pop;
  assign rd_empty = rd_rhold & rx_qen & rx_empty;
  assign tm_read = rd_rhold & rx_qen & rx_tm & (rx_cnt > 4'h1);
  assign rx_thr = rx_frame_in & rx_qen & ~rx_tm & ~rx_full &
    ((rx_cnt + 4'h1) == rx_lvl);
  assign rx_each = rx_frame_in & (~rx_qen | rx_tm);

  // a take in the same cycle makes room for the write
  // transmit overflow
  assign tx_ovf = wr_thold & tx_qen & tx_full & ~tx_take_ev;
  // holding word moved to the shifter
  assign tx_take_ev = tx_take_in & ~tx_empty;
  assign tb_take = tx_take_ev & (~tx_qen | tx_tm | ((tx_cnt - 4'h1) == tx_lvl));
  assign tx_enable_ev = wr_txfc & reg_wdata_in[`SIRQ_QEN] & reg_wdata_in[`SIRQ_QTM] &
    ~tx_qen;

  // event collection per request line
  // several error causes raise the receive line as well
  assign rx_ev = rx_each | rx_thr | rx_ovf | sync_err | framing_err | parity_err | tm_read;
  assign er_ev = rx_ovf | sync_err | overrun_ev | rd_empty | tx_ovf | framing_err |
    parity_err;
  assign tb_ev = tb_take | (wr_txfc & reg_wdata_in[`SIRQ_QFLU]) | tx_enable_ev;
  // bit order matches the status and mask registers
  assign ev = {tb_ev, er_ev, rx_ev};

  sirq_stretch u_stretch (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .ev_in(ev),
    .line_out(lines)
  );

  // stretched lines onto the request pins
  assign receive_request_line_out = lines[0];
  assign error_request_line_out = lines[1];
  assign transmit_holding_request_line_out = lines[2];

  // port control, error flags are set by hardware and win over a clear
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      port_control <= `SIRQ_PCON_RST;
    end else begin
      // software write first, flag and enable updates below override it
      if (wr_pcon) begin
        port_control <= reg_wdata_in;
      end
      port_control[`SIRQ_OE] <= (wr_pcon ? reg_wdata_in[`SIRQ_OE] : port_control[`SIRQ_OE]) |
        overrun_ev;
      port_control[`SIRQ_FE] <= (wr_pcon ? reg_wdata_in[`SIRQ_FE] : port_control[`SIRQ_FE]) |
        framing_err;
      port_control[`SIRQ_PE] <= (wr_pcon ? reg_wdata_in[`SIRQ_PE] : port_control[`SIRQ_PE]) |
        parity_err;
      // receiver stops after each synchronous frame
      if (rx_frame_in & sync_mode) begin
        port_control[`SIRQ_REN] <= 1'b0;
      end
    end
  end

  // queue controls, the flush bit is an action and reads back zero
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      tx_queue_control <= `SIRQ_QCON_RST;
      rx_queue_control <= `SIRQ_QCON_RST;
    end else begin
      if (wr_txfc) begin
        tx_queue_control <= reg_wdata_in & ~(16'h1 << `SIRQ_QFLU);
      end
      if (wr_rxfc) begin
        rx_queue_control <= reg_wdata_in & ~(16'h1 << `SIRQ_QFLU);
      end
    end
  end

  // last written transmit word, kept for read back
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      transmit_holding <= 16'h0000;
    end else if (wr_thold) begin
      transmit_holding <= reg_wdata_in;
    end
  end

  // word handed to the shifter
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      tx_data_out <= 9'h000;
    end else if (tx_take_ev) begin
      tx_data_out <= tx_head;
    end
  end

  // sticky interrupt status, cleared by reading it, a new event wins
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      irq_status <= 3'h0;
      irq_mask <= `SIRQ_MASK_RST;
    end else begin
      irq_status <= (rd_stat ? 3'h0 : irq_status) | ev;
      // mask is plain storage
      if (wr_mask) begin
        irq_mask <= reg_wdata_in[2:0];
      end
    end
  end

  // level request while any unmasked status bit is set
  assign irq_out = |(irq_status & irq_mask);

  // read data, valid in the cycle after the strobe
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_rd_in) begin
      // a holding read pops at this edge, so the head is latched first
      case (reg_addr_in)
        `SIRQ_A_PCON: begin
          reg_rdata_out <= port_control;
        end
        `SIRQ_A_TXFCON: begin
          reg_rdata_out <= tx_queue_control;
        end
        `SIRQ_A_RXFCON: begin
          reg_rdata_out <= rx_queue_control;
        end
        `SIRQ_A_FSTAT: begin
          reg_rdata_out <= {4'h0, tx_cnt, 4'h0, rx_cnt};
        end
        `SIRQ_A_THOLD: begin
          reg_rdata_out <= transmit_holding;
        end
        `SIRQ_A_RHOLD: begin
          reg_rdata_out <= rx_empty ? 16'h0000 : {7'h00, rx_head};
        end
        `SIRQ_A_ISTAT: begin
          reg_rdata_out <= {13'h0000, irq_status};
        end
        `SIRQ_A_IMASK: begin
          reg_rdata_out <= {13'h0000, irq_mask};
        end
        default: begin
          reg_rdata_out <= 16'h0000;
        end
      endcase
    end else begin
      reg_rdata_out <= 16'h0000;
    end
  end
endmodule

// ==== sirq_event_logic_assertions.sv ====
`timescale 1ns/100ps
`include "sirq_consts.vh"
module sirq_chk (
  input wire core_clk_in,
  input wire rst_in,
  input wire [15:0] reg_addr_in,
  input wire [15:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [15:0] reg_rdata_out,
  input wire rx_frame_in,
  input wire [8:0] rx_data_in,
  input wire rx_stop_in,
  input wire receive_request_line_out,
  input wire error_request_line_out,
  input wire transmit_holding_request_line_out
);
  reg [15:0] pcon;
  reg tx_en;
  wire rr = receive_request_line_out;
  wire er = error_request_line_out;
  wire tr = transmit_holding_request_line_out;
  wire txw = reg_wr_in && reg_addr_in == `SIRQ_A_TXFCON;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // mirror of software written mode, check and enable bits
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      pcon <= 16'h0000;
      tx_en <= 1'b0;
    end else if (reg_wr_in) begin
      if (reg_addr_in == `SIRQ_A_PCON) pcon <= reg_wdata_in;
      if (txw) tx_en <= reg_wdata_in[0];
    end
  end
  property p_rr_w; $rose(rr) |-> rr [*2]; endproperty
  property p_er_w; $fell(er) |-> $past(er, 2); endproperty
  property p_tr_w; tr && !$past(tr) |=> tr; endproperty
  property p_rd_idle; !$past(reg_rd_in) |-> reg_rdata_out == 16'h0000; endproperty
  property p_flush; txw && reg_wdata_in[1] |=> tr; endproperty
  property p_tx_on; txw && reg_wdata_in[0] && reg_wdata_in[2] && !tx_en |=> tr; endproperty
  property p_frame;
    rx_frame_in && !rx_stop_in && pcon[6] && pcon[2:0] != 3'h0 |=> rr && er;
  endproperty
  property p_parity;
    rx_frame_in && pcon[5] && pcon[2:0] == 3'h7 && (^rx_data_in != pcon[12]) |=> rr && er;
  endproperty
  a_rr_w: assert property (p_rr_w) else $error("receive line too short");
  a_er_w: assert property (p_er_w) else $error("error line too short");
  a_tr_w: assert property (p_tr_w) else $error("transmit line too short");
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  a_flush: assert property (p_flush) else $error("no request on flush");
  a_tx_on: assert property (p_tx_on) else $error("no request on enable");
  a_frame: assert property (p_frame) else $error("no framing requests");
  a_parity: assert property (p_parity) else $error("no parity requests");
  c_frame: cover property (rx_frame_in && !rx_stop_in);
  c_flush: cover property (txw && reg_wdata_in[1]);
  c_err: cover property ($rose(er));
endmodule
bind sirq_event_logic sirq_chk u_chk (.core_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in,
  .reg_wr_in, .reg_rd_in, .reg_rdata_out, .rx_frame_in, .rx_data_in, .rx_stop_in,
  .receive_request_line_out, .error_request_line_out, .transmit_holding_request_line_out);

// ==== sirq_event_logic_tb.sv ====
`timescale 1ns/100ps
`include "sirq_consts.vh"
module sirq_event_logic_tb;
  reg core_clk_in = 1'b0;
  reg rst_in = 1'b1;
  reg [15:0] addr = 16'h0000;
  reg [15:0] wdata = 16'h0000;
  reg wr = 1'b0;
  reg rd = 1'b0;
  wire [15:0] rdata;
  wire [8:0] rxd;
  wire [8:0] txd;
  wire rxf, rxs, take, rdy, rr, er, tr, irq;
  reg rr_q = 1'b0, er_q = 1'b0, tr_q = 1'b0;
  int n_mismatch = 0;
  int n_tests = 0;
  int cr = 0, ce = 0, ct = 0;
  int hr = 0, he = 0, ht = 0;
  int i;
  always #2 core_clk_in = ~core_clk_in;
  sirq_event_logic dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .rx_frame_in(rxf), .rx_data_in(rxd), .rx_stop_in(rxs), .tx_take_in(take),
    .tx_data_out(txd), .tx_ready_out(rdy), .receive_request_line_out(rr),
    .error_request_line_out(er), .transmit_holding_request_line_out(tr), .irq_out(irq));
  sirq_link_model link (.core_clk_in(core_clk_in), .rst_in(rst_in), .tx_ready_in(rdy),
    .tx_data_in(txd), .rx_frame_out(rxf), .rx_data_out(rxd), .rx_stop_out(rxs),
    .tx_take_out(take));
  // count request events by their rising edges, and active cycles
  always @(posedge core_clk_in) begin
    rr_q <= rr;
    er_q <= er;
    tr_q <= tr;
    if (rr && !rr_q) cr++;
    if (er && !er_q) ce++;
    if (tr && !tr_q) ct++;
    if (rr) hr++;
    if (er) he++;
    if (tr) ht++;
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr_reg(input [15:0] a, input [15:0] d);
    @(posedge core_clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk_in);
    wr <= 1'b0;
  endtask
  task rd_reg(input [15:0] a, input [15:0] e);
    @(posedge core_clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk_in);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // compare request events since the last call
  task ev(input [15:0] r, input [15:0] e, input [15:0] t);
    repeat (4) @(posedge core_clk_in);
    #1 chk(cr[15:0], r);
    chk(ce[15:0], e);
    chk(ct[15:0], t);
    chk(hr[15:0], {r[14:0], 1'b0});
    chk(he[15:0], {e[14:0], 1'b0});
    chk(ht[15:0], {t[14:0], 1'b0});
    cr = 0;
    ce = 0;
    ct = 0;
    hr = 0;
    he = 0;
    ht = 0;
  endtask
  task test_done;
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // cut a hang short
  initial begin
    #40000;
    n_mismatch++;
    test_done;
  end
  // main sequence
  initial begin
    repeat (16) @(posedge core_clk_in);
    rst_in <= 1'b0;
    rd_reg(`SIRQ_A_PCON, 16'h0000);
    rd_reg(`SIRQ_A_RXFCON, 16'h0100);
    wr_reg(`SIRQ_A_BG, 16'h1234);
    rd_reg(`SIRQ_A_BG, 16'h0000);
    wr_reg(`SIRQ_A_PCON, 16'h0001);
    link.send(9'h05a, 1'b1);
    ev(1, 0, 0);
    rd_reg(`SIRQ_A_RHOLD, 16'h005a);
    wr_reg(`SIRQ_A_PCON, 16'h0090);
    link.send(9'h011, 1'b1);
    ev(1, 0, 0);
    link.send(9'h022, 1'b1);
    ev(1, 1, 0);
    rd_reg(`SIRQ_A_PCON, 16'h0480);
    rd_reg(`SIRQ_A_RHOLD, 16'h0022);
    wr_reg(`SIRQ_A_PCON, 16'h0067);
    link.send(9'h003, 1'b0);
    ev(1, 1, 0);
    link.send(9'h001, 1'b1);
    ev(1, 1, 0);
    rd_reg(`SIRQ_A_PCON, 16'h0367);
    wr_reg(`SIRQ_A_PCON, 16'h1067);
    link.send(9'h001, 1'b1);
    ev(1, 0, 0);
    wr_reg(`SIRQ_A_PCON, 16'h0023);
    link.send(9'h101, 1'b1);
    ev(1, 1, 0);
    wr_reg(`SIRQ_A_PCON, 16'h0001);
    wr_reg(`SIRQ_A_RXFCON, 16'h0301);
    for (i = 0; i < 3; i++) link.send(i[8:0], 1'b1);
    ev(1, 0, 0);
    for (i = 3; i < 8; i++) link.send(i[8:0], 1'b1);
    ev(0, 0, 0);
    link.send(9'h0ff, 1'b1);
    ev(1, 1, 0);
    rd_reg(`SIRQ_A_FSTAT, 16'h0008);
    for (i = 0; i < 7; i++) rd_reg(`SIRQ_A_RHOLD, i[15:0]);
    rd_reg(`SIRQ_A_RHOLD, 16'h00ff);
    rd_reg(`SIRQ_A_RHOLD, 16'h0000);
    ev(0, 1, 0);
    rd_reg(`SIRQ_A_FSTAT, 16'h0000);
    wr_reg(`SIRQ_A_RXFCON, 16'h0105);
    link.send(9'h0a1, 1'b1);
    ev(1, 0, 0);
    link.send(9'h0a2, 1'b1);
    ev(1, 0, 0);
    rd_reg(`SIRQ_A_RHOLD, 16'h00a1);
    ev(1, 0, 0);
    rd_reg(`SIRQ_A_RHOLD, 16'h00a2);
    ev(0, 0, 0);
    wr_reg(`SIRQ_A_TXFCON, 16'h0002);
    ev(0, 0, 1);
    rd_reg(`SIRQ_A_TXFCON, 16'h0000);
    wr_reg(`SIRQ_A_TXFCON, 16'h0105);
    ev(0, 0, 1);
    for (i = 0; i < 9; i++) wr_reg(`SIRQ_A_THOLD, 16'h0030 + i[15:0]);
    ev(0, 1, 0);
    rd_reg(`SIRQ_A_FSTAT, 16'h0800);
    rd_reg(`SIRQ_A_THOLD, 16'h0038);
    link.take_gap = 3;
    for (i = 0; i < 200 && rdy !== 1'b0; i++) @(posedge core_clk_in);
    ev(0, 0, 8);
    chk({7'h00, link.last_tx}, 16'h0038);
    wr_reg(`SIRQ_A_IMASK, 16'h0007);
    rd_reg(`SIRQ_A_ISTAT, 16'h0007);
    link.send(9'h0c3, 1'b1);
    ev(1, 0, 0);
    chk({15'h0000, irq}, 16'h0001);
    wr_reg(`SIRQ_A_IMASK, 16'h0006);
    #1 chk({15'h0000, irq}, 16'h0000);
    rd_reg(`SIRQ_A_ISTAT, 16'h0001);
    wr_reg(`SIRQ_A_IMASK, 16'h0007);
    #1 chk({15'h0000, irq}, 16'h0000);
    rd_reg(`SIRQ_A_IMASK, 16'h0007);
    test_done;
  end
endmodule

// ==== sirq_link_model.sv ====
`timescale 1ns/100ps
module sirq_link_model (
  input wire core_clk_in,
  input wire rst_in,
  input wire tx_ready_in,
  input wire [8:0] tx_data_in,
  output reg rx_frame_out,
  output reg [8:0] rx_data_out,
  output reg rx_stop_out,
  output reg tx_take_out
);
  int take_gap = 1000000;
  int wait_cnt = 0;
  reg take_d = 1'b0;
  reg [8:0] last_tx = 9'h000;
  // line idle at start
  initial begin
    rx_frame_out = 1'b0;
    rx_data_out = 9'h000;
    rx_stop_out = 1'b1;
    tx_take_out = 1'b0;
  end
  task send(input logic [8:0] d, input logic stop_ok);
    @(posedge core_clk_in);
    rx_frame_out <= 1'b1;
    rx_data_out <= d;
    rx_stop_out <= stop_ok;
    @(posedge core_clk_in);
    rx_frame_out <= 1'b0;
    rx_data_out <= ~d;
    rx_stop_out <= ~stop_ok;
  endtask
  // take transmit words after a wait, stalling while the wait is long
  always @(posedge core_clk_in) begin
    take_d <= tx_take_out;
    if (take_d) last_tx <= tx_data_in;
    if (rst_in || !tx_ready_in || tx_take_out) begin
      wait_cnt <= 0;
      tx_take_out <= 1'b0;
    end else if (wait_cnt >= take_gap) begin
      tx_take_out <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 1;
    end
  end
endmodule

// ==== sirq_queue.v ====
`timescale 1ns/100ps
`include "sirq_consts.vh"
module sirq_queue (
  input wire core_clk_in,
  input wire rst_in,
  input wire flush_in,
  input wire push_in,
  input wire pop_in,
  input wire [8:0] data_in,
  input wire [3:0] cap_in,
  output wire [8:0] head_out,
  output wire [3:0] count_out,
  output wire full_out,
  output wire empty_out
);
  reg [8:0] mem [0:7];
  reg [2:0] wp;
  reg [2:0] rp;
  reg [3:0] cnt;
  wire do_pop;
  wire do_push;
  wire ovw;
  // full is relative to the configured capacity
  assign full_out = (cnt >= cap_in);
  assign empty_out = (cnt == 4'h0);
  assign count_out = cnt;
  assign head_out = mem[rp];
  assign do_pop = pop_in & ~empty_out;
  assign do_push = push_in & (~full_out | do_pop);
  assign ovw = push_in & full_out & ~do_pop;
  // storage, an overflow replaces the newest entry
  always @(posedge core_clk_in) begin
    if (do_push) begin
      mem[wp] <= data_in;
    end else if (ovw) begin
      mem[wp - 3'h1] <= data_in;
    end
  end
  // pointers and fill count, empty pops and overflows leave count alone
  always @(posedge core_clk_in) begin
    if (rst_in | flush_in) begin
      wp <= 3'h0;
      rp <= 3'h0;
      cnt <= 4'h0;
    end else begin
      if (do_push) begin
        wp <= wp + 3'h1;
      end
      if (do_pop) begin
        rp <= rp + 3'h1;
      end
      if (do_push & ~do_pop) begin
        cnt <= cnt + 4'h1;
      end else if (do_pop & ~do_push) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule

// ==== sirq_stretch.v ====
`timescale 1ns/100ps
`include "sirq_consts.vh"
module sirq_stretch (
  input wire core_clk_in,
  input wire rst_in,
  input wire [2:0] ev_in,
  output wire [2:0] line_out
);
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_line
      reg act;
      reg [1:0] left;
      // request held for a fixed count, a new event restarts it
      always @(posedge core_clk_in) begin
        if (rst_in) begin
          act <= 1'b0;
          left <= 2'h0;
        end else if (ev_in[i]) begin
          act <= 1'b1;
          left <= `SIRQ_REQ_CYC - 2'h1;
        end else if (left != 2'h0) begin
          left <= left - 2'h1;
        end else begin
          act <= 1'b0;
        end
      end
      assign line_out[i] = act;
    end
  endgenerate
endmodule
